// ### rtl/rsb_defs.svh
// constants for the reset strap and external bus select block
// assumes inclusion by the rsb package and the top module only
`ifndef RSB_DEFS_SVH
`define RSB_DEFS_SVH

// register map on the i/o port space
`define RSB_EBS_ADDR 16'h1C00
`define RSB_EBS_RESET 16'h0000
// writable bits: 14:8 and 5:0, reserved 15 and 7:6 read zero
`define RSB_EBS_WMASK 16'h7F3F

// field positions
`define RSB_PP_MSB 14
`define RSB_PP_LSB 12
`define RSB_SP1_MSB 11
`define RSB_SP1_LSB 10
`define RSB_SP0_MSB 9
`define RSB_SP0_LSB 8
`define RSB_AMODE_MSB 5
`define RSB_AMODE_LSB 0

// pin counts
`define RSB_PP_PINS 21
`define RSB_SP_PINS 6
`define RSB_EMA_PINS 6

// serial port mode codes
`define RSB_SP_MODE0 2'h0
`define RSB_SP_MODE1 2'h1
`define RSB_SP_MODE2 2'h2

// cycles after reset release before straps are latched (synchroniser depth)
`define RSB_STRAP_WAIT 2'h2

`endif

// ### rtl/rsb_pkg.sv
// types shared by the reset strap and external bus select block
// assumes rsb_defs.svh sits in the include path
`include "rsb_defs.svh"

package rsb_pkg;

    // which peripheral owns a multiplexed pin
    typedef enum logic [2:0] {
        OWN_NONE,
        OWN_SPI,
        OWN_UART,
        OWN_I2S2,
        OWN_I2S3,
        OWN_GPIO,
        OWN_MMC,
        OWN_I2S
    } rsb_owner_e;

    // pin-aligned drive bundle for the parallel port
    typedef struct packed {
        logic [`RSB_PP_PINS-1:0] out;
        logic [`RSB_PP_PINS-1:0] oe_n;
    } rsb_pp_drv_s;

    // pin-aligned drive bundle for a serial port or the upper address pins
    typedef struct packed {
        logic [`RSB_SP_PINS-1:0] out;
        logic [`RSB_SP_PINS-1:0] oe_n;
    } rsb_sp_drv_s;

    // one i/o port request
    typedef struct packed {
        logic sel;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } rsb_io_req_s;

endpackage

// ### rtl/rsb_top.sv
// reset straps and external bus select pin multiplexer
// assumes all pin inputs are asynchronous to sys_clk; peripherals are on sys_clk
//
// Summary of operation
// - strap low: regulator on, monitor makes power_ok
// - strap high: regulator off, power_ok high, pin reset
// - clock strap low: oscillator clocks everything
// - clock strap high: external clock drives generator
// - select register routes parallel and serial pins
// - select register decoded at port 0x1C00
// - new routing applies on following clock cycle
// - per-pin bit turns address pins 20:15 GPIO
// - parallel field 14:12 selects groupings 0 to 6
// - serial port 1 field 11:10 decoded
// - serial port 0 field 9:8 decoded
`timescale 1ns/100ps
`include "rsb_defs.svh"

module rsb_top
    import rsb_pkg::*;
#(
    parameter int PP_PINS = `RSB_PP_PINS
) (
    input wire logic sys_clk,
    input wire logic nrst,
    // i/o port access
    input wire rsb_io_req_s io_req,
    output logic [15:0] io_rdata,
    output logic io_rvalid,
    // configuration straps and regulator monitor
    input wire logic regulator_enable_strap,
    input wire logic clock_select_strap,
    input wire logic regulator_output_ok,
    output logic core_regulator_en,
    output logic por_monitor_en,
    output logic power_ok,
    output logic reset_from_pin_only,
    output logic main_clk_from_external,
    output logic external_clock_input_en,
    // peripheral drive bundles
    input wire rsb_pp_drv_s spi_pp,
    input wire rsb_pp_drv_s uart_pp,
    input wire rsb_pp_drv_s i2s2_pp,
    input wire rsb_pp_drv_s i2s3_pp,
    input wire rsb_pp_drv_s gpio_pp,
    input wire rsb_sp_drv_s mmc0_sp,
    input wire rsb_sp_drv_s i2s0_sp,
    input wire rsb_sp_drv_s gpio0_sp,
    input wire rsb_sp_drv_s mmc1_sp,
    input wire rsb_sp_drv_s i2s1_sp,
    input wire rsb_sp_drv_s gpio1_sp,
    input wire rsb_sp_drv_s emif_ema,
    input wire rsb_sp_drv_s gpio_ema,
    // pins
    input wire logic [PP_PINS-1:0] pp_pin_in,
    output logic [PP_PINS-1:0] pp_pin_out,
    output logic [PP_PINS-1:0] pp_pin_oe_n,
    input wire logic [`RSB_SP_PINS-1:0] sp0_pin_in,
    output logic [`RSB_SP_PINS-1:0] sp0_pin_out,
    output logic [`RSB_SP_PINS-1:0] sp0_pin_oe_n,
    input wire logic [`RSB_SP_PINS-1:0] sp1_pin_in,
    output logic [`RSB_SP_PINS-1:0] sp1_pin_out,
    output logic [`RSB_SP_PINS-1:0] sp1_pin_oe_n,
    input wire logic [`RSB_EMA_PINS-1:0] ema_pin_in,
    output logic [`RSB_EMA_PINS-1:0] ema_pin_out,
    output logic [`RSB_EMA_PINS-1:0] ema_pin_oe_n,
    // synchronised pin levels for the peripherals
    output logic [PP_PINS-1:0] pp_pin_sync,
    output logic [`RSB_SP_PINS-1:0] sp0_pin_sync,
    output logic [`RSB_SP_PINS-1:0] sp1_pin_sync,
    output logic [`RSB_EMA_PINS-1:0] ema_pin_sync
);

    localparam int IN_W = PP_PINS + 3 * `RSB_SP_PINS + 3;

    // parallel port owner per mode and pin; mode 0 and code 7 leave pins undriven
    function automatic rsb_owner_e pp_owner(input logic [2:0] mode, input int idx);
        rsb_owner_e o;
        o = OWN_NONE;
        unique case (mode)
            3'h1: o = (idx < 7) ? OWN_SPI : (idx < 13) ? OWN_GPIO : (idx < 17) ? OWN_UART : OWN_I2S2;
            3'h2: o = (idx < 8) ? OWN_GPIO : OWN_NONE;
            3'h3: o = (idx < 4) ? OWN_SPI : (idx < 8) ? OWN_I2S3 : OWN_NONE;
            3'h4: o = (idx < 4) ? OWN_I2S2 : (idx < 8) ? OWN_UART : OWN_NONE;
            3'h5: o = (idx < 4) ? OWN_SPI : (idx < 8) ? OWN_UART : OWN_NONE;
            3'h6: o = (idx < 7) ? OWN_SPI : (idx < 11) ? OWN_I2S2 : (idx < 15) ? OWN_I2S3 : OWN_GPIO;
            default: o = OWN_NONE; // mode 0 and reserved code 7
        endcase
        return o;
    endfunction

    // serial port owner; reserved code 3 leaves the pins undriven
    function automatic rsb_owner_e sp_owner(input logic [1:0] mode, input int idx);
        rsb_owner_e o;
        o = OWN_NONE;
        unique case (mode)
            `RSB_SP_MODE0: o = OWN_MMC;
            `RSB_SP_MODE1: o = (idx < 4) ? OWN_I2S : OWN_GPIO;
            `RSB_SP_MODE2: o = OWN_GPIO;
            default: o = OWN_NONE;
        endcase
        return o;
    endfunction

    // register and strap state
    logic [15:0] ebs_r; // external_bus_select contents
    logic [15:0] ebs_nxt;
    logic [15:0] rdata_r;
    logic rvalid_r;
    logic [IN_W-1:0] in_meta_r; // first synchroniser stage, read only by in_sync_r
    logic [IN_W-1:0] in_sync_r;
    logic [1:0] wait_cnt_r; // counts synchroniser fill after reset release
    logic straps_held_r;
    logic reg_strap_r; // latched regulator strap
    logic clk_strap_r; // latched clock strap

    // decode wires
    wire ebs_hit = io_req.sel && (io_req.addr == `RSB_EBS_ADDR);
    wire ebs_wr = ebs_hit && io_req.wr;
    wire ebs_rd = io_req.sel && !io_req.wr;
    wire [2:0] pp_mode = ebs_r[`RSB_PP_MSB:`RSB_PP_LSB];
    wire [1:0] sp1_mode = ebs_r[`RSB_SP1_MSB:`RSB_SP1_LSB];
    wire [1:0] sp0_mode = ebs_r[`RSB_SP0_MSB:`RSB_SP0_LSB];
    wire [`RSB_EMA_PINS-1:0] ema_gpio = ebs_r[`RSB_AMODE_MSB:`RSB_AMODE_LSB];
    wire pin_regulator_strap = in_sync_r[IN_W-1];
    wire pin_clock_strap = in_sync_r[IN_W-2];
    wire pin_reg_ok = in_sync_r[IN_W-3];

    // reserved bits never store, so they read back as zero
    assign ebs_nxt = ebs_wr ? (io_req.wdata & `RSB_EBS_WMASK) : ebs_r;

    // register write; routing follows the stored value from the next edge on
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ebs_r <= `RSB_EBS_RESET;
        end else begin
            ebs_r <= ebs_nxt;
        end
    end

    // read data is registered; unmapped addresses read zero
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rdata_r <= 16'h0000;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= (ebs_rd && ebs_hit) ? ebs_r : 16'h0000;
            rvalid_r <= ebs_rd;
        end
    end

    assign io_rdata = rdata_r;
    assign io_rvalid = rvalid_r;

    // two-stage synchroniser for every asynchronous pin level
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            in_meta_r <= '0;
            in_sync_r <= '0;
        end else begin
            in_meta_r <= {regulator_enable_strap, clock_select_strap, regulator_output_ok,
                          ema_pin_in, sp1_pin_in, sp0_pin_in, pp_pin_in};
            in_sync_r <= in_meta_r;
        end
    end

    assign pp_pin_sync = in_sync_r[PP_PINS-1:0];
    assign sp0_pin_sync = in_sync_r[PP_PINS +: `RSB_SP_PINS];
    assign sp1_pin_sync = in_sync_r[PP_PINS + `RSB_SP_PINS +: `RSB_SP_PINS];
    assign ema_pin_sync = in_sync_r[PP_PINS + 2 * `RSB_SP_PINS +: `RSB_EMA_PINS];

    // straps are caught once the synchroniser has filled, then frozen until the next reset;
    // a strap moved while running is ignored, which is why a reset must follow any change
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            wait_cnt_r <= 2'h0;
            straps_held_r <= 1'b0;
            reg_strap_r <= 1'b0;
            clk_strap_r <= 1'b0;
        end else if (!straps_held_r) begin
            wait_cnt_r <= wait_cnt_r + 2'h1;
            if (wait_cnt_r == `RSB_STRAP_WAIT) begin
                straps_held_r <= 1'b1;
                reg_strap_r <= pin_regulator_strap;
                clk_strap_r <= pin_clock_strap;
            end
        end
    end

    // regulator and power monitor control
    assign core_regulator_en = !reg_strap_r;
    assign por_monitor_en = !reg_strap_r;
    assign power_ok = reg_strap_r ? 1'b1 : pin_reg_ok;
    assign reset_from_pin_only = reg_strap_r;

    // clock source select; the real-time clock always runs from the oscillator
    assign main_clk_from_external = clk_strap_r;
    assign external_clock_input_en = clk_strap_r;

    // parallel port routing, one mux per pin
    genvar gi;
    generate
        for (gi = 0; gi < PP_PINS; gi++) begin : g_pp
            wire rsb_owner_e own = pp_owner(pp_mode, gi);
            logic o;
            logic e;
            always_comb begin
                o = 1'b0;
                e = 1'b1; // undriven unless a peripheral owns the pin
                unique case (own)
                    OWN_SPI: begin
                        o = spi_pp.out[gi];
                        e = spi_pp.oe_n[gi];
                    end
                    OWN_UART: begin
                        o = uart_pp.out[gi];
                        e = uart_pp.oe_n[gi];
                    end
                    OWN_I2S2: begin
                        o = i2s2_pp.out[gi];
                        e = i2s2_pp.oe_n[gi];
                    end
                    OWN_I2S3: begin
                        o = i2s3_pp.out[gi];
                        e = i2s3_pp.oe_n[gi];
                    end
                    OWN_GPIO: begin
                        o = gpio_pp.out[gi];
                        e = gpio_pp.oe_n[gi];
                    end
                    default: begin
                        o = 1'b0;
                        e = 1'b1;
                    end
                endcase
            end
            assign pp_pin_out[gi] = o;
            assign pp_pin_oe_n[gi] = e;
        end

        // serial ports and upper address pins share the six-pin loop
        for (gi = 0; gi < `RSB_SP_PINS; gi++) begin : g_sp
            wire rsb_owner_e own0 = sp_owner(sp0_mode, gi);
            wire rsb_owner_e own1 = sp_owner(sp1_mode, gi);
            assign sp0_pin_out[gi] = (own0 == OWN_MMC) ? mmc0_sp.out[gi] :
                                     (own0 == OWN_I2S) ? i2s0_sp.out[gi] :
                                     (own0 == OWN_GPIO) ? gpio0_sp.out[gi] : 1'b0;
            assign sp0_pin_oe_n[gi] = (own0 == OWN_MMC) ? mmc0_sp.oe_n[gi] :
                                      (own0 == OWN_I2S) ? i2s0_sp.oe_n[gi] :
                                      (own0 == OWN_GPIO) ? gpio0_sp.oe_n[gi] : 1'b1;
            assign sp1_pin_out[gi] = (own1 == OWN_MMC) ? mmc1_sp.out[gi] :
                                     (own1 == OWN_I2S) ? i2s1_sp.out[gi] :
                                     (own1 == OWN_GPIO) ? gpio1_sp.out[gi] : 1'b0;
            assign sp1_pin_oe_n[gi] = (own1 == OWN_MMC) ? mmc1_sp.oe_n[gi] :
                                      (own1 == OWN_I2S) ? i2s1_sp.oe_n[gi] :
                                      (own1 == OWN_GPIO) ? gpio1_sp.oe_n[gi] : 1'b1;
            // each address pin has its own select bit: 1 gives the pin to GPIO
            assign ema_pin_out[gi] = ema_gpio[gi] ? gpio_ema.out[gi] : emif_ema.out[gi];
            assign ema_pin_oe_n[gi] = ema_gpio[gi] ? gpio_ema.oe_n[gi] : emif_ema.oe_n[gi];
        end
    endgenerate

    // software sequencing (clock gate before change, peripheral reset after, single
    // write after boot) is not enforced here: bind software, and a
    // mid-run rewrite simply switches the muxes at the next edge
endmodule

// ### testbench/rsb_top_checker.sv
// port-level assertions for the strap and bus select block
// assumes one sys_clk domain; attached by the bind at the foot
`timescale 1ns/100ps
module rsb_top_checker
    import rsb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire rsb_io_req_s io_req,
    input wire logic [15:0] io_rdata,
    input wire logic io_rvalid,
    input wire logic core_regulator_en,
    input wire logic por_monitor_en,
    input wire logic power_ok,
    input wire logic reset_from_pin_only,
    input wire logic main_clk_from_external,
    input wire logic external_clock_input_en,
    input wire rsb_sp_drv_s gpio0_sp,
    input wire rsb_sp_drv_s emif_ema,
    input wire rsb_sp_drv_s gpio_ema,
    input wire logic [5:0] sp0_pin_out,
    input wire logic [5:0] ema_pin_out
);
    // edges since reset release, saturating; straps are settled long before 7
    logic [2:0] up_r;
    logic [2:0] up_nxt;
    // a taken write to the select register, and any read request
    wire wr_hit = io_req.sel && io_req.wr && (io_req.addr == 16'h1C00);
    wire rd_req = io_req.sel && !io_req.wr;
    assign up_nxt = (up_r == 3'h7) ? up_r : up_r + 3'h1;
    // counter clears in reset so a mid-run reset restarts the settle window
    always_ff @(posedge sys_clk) begin
        up_r <= nrst ? up_nxt : 3'h0;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    pok_forced_a: assert property (reset_from_pin_only |-> power_ok)
        else $error("power ok low with regulator off");
    reg_enable_a: assert property (core_regulator_en == !reset_from_pin_only && por_monitor_en == core_regulator_en)
        else $error("regulator enable disagrees with strap");
    clk_source_a: assert property (main_clk_from_external == external_clock_input_en)
        else $error("clock source outputs disagree");
    strap_hold_a: assert property (up_r == 3'h7 |-> $stable(reset_from_pin_only) && $stable(main_clk_from_external))
        else $error("strap outputs moved after latch");
    read_ans_a: assert property (rd_req |=> io_rvalid)
        else $error("read not answered");
    rvalid_pulse_a: assert property (!rd_req |=> !io_rvalid)
        else $error("read valid without request");
    unmapped_zero_a: assert property (rd_req && io_req.addr != 16'h1C00 |=> io_rdata == 16'h0000)
        else $error("unmapped read data not zero");
    resv_zero_a: assert property (io_rvalid |-> io_rdata[15] == 1'b0 && io_rdata[7:6] == 2'h0)
        else $error("reserved bits read nonzero");
    ema_route_a: assert property (wr_hit |=> ema_pin_out ==
        ((gpio_ema.out & $past(io_req.wdata[5:0])) | (emif_ema.out & ~$past(io_req.wdata[5:0]))))
        else $error("address pin routing wrong");
    sp0_gpio_a: assert property (wr_hit && io_req.wdata[9:8] == 2'h2 |=> sp0_pin_out == gpio0_sp.out)
        else $error("serial port 0 gpio routing wrong");
endmodule

bind rsb_top rsb_top_checker chk_u (.sys_clk(sys_clk), .nrst(nrst), .io_req(io_req), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .core_regulator_en(core_regulator_en), .por_monitor_en(por_monitor_en),
    .power_ok(power_ok), .reset_from_pin_only(reset_from_pin_only), .main_clk_from_external(main_clk_from_external),
    .external_clock_input_en(external_clock_input_en), .gpio0_sp(gpio0_sp), .emif_ema(emif_ema),
    .gpio_ema(gpio_ema), .sp0_pin_out(sp0_pin_out), .ema_pin_out(ema_pin_out));

// ### testbench/rsb_top_tb_top.sv
// self-checking bench for the strap and bus select block
// assumes the package and rtl/rsb_top.sv are compiled first
`timescale 1ns/100ps
module rsb_top_tb_top import rsb_pkg::*;;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    rsb_io_req_s io_req = '0;
    logic reg_strap = 1'b0;
    logic clk_strap = 1'b0;
    logic ok_lvl = 1'b0;
    logic [20:0] pin_in = 21'h0A_5A5A;
    // parallel drives: 0 none, 1 spi, 2 uart, 3 i2s2, 4 i2s3, 5 gpio
    rsb_pp_drv_s pp_d[6];
    // serial drives: mmc0 i2s0 gpio0 mmc1 i2s1 gpio1 emif gpio-address
    rsb_sp_drv_s sp_d[8];
    logic [15:0] io_rdata;
    logic io_rvalid, cre, pme, pok, rpo, mce, eci;
    logic [20:0] pp_out, pp_oe, pp_sync;
    logic [5:0] sp0_sync, sp1_sync, ema_sync;
    logic [5:0] sp0_out, sp0_oe, sp1_out, sp1_oe, ema_out, ema_oe;
    int n_tests = 0;
    int n_mismatch = 0;
    rsb_top dut_u (.sys_clk(sys_clk), .nrst(nrst), .io_req(io_req), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
        .regulator_enable_strap(reg_strap), .clock_select_strap(clk_strap), .regulator_output_ok(ok_lvl),
        .core_regulator_en(cre), .por_monitor_en(pme), .power_ok(pok), .reset_from_pin_only(rpo),
        .main_clk_from_external(mce), .external_clock_input_en(eci), .spi_pp(pp_d[1]), .uart_pp(pp_d[2]),
        .i2s2_pp(pp_d[3]), .i2s3_pp(pp_d[4]), .gpio_pp(pp_d[5]), .mmc0_sp(sp_d[0]), .i2s0_sp(sp_d[1]),
        .gpio0_sp(sp_d[2]), .mmc1_sp(sp_d[3]), .i2s1_sp(sp_d[4]), .gpio1_sp(sp_d[5]), .emif_ema(sp_d[6]),
        .gpio_ema(sp_d[7]), .pp_pin_in(pin_in), .pp_pin_out(pp_out), .pp_pin_oe_n(pp_oe),
        .sp0_pin_in(pin_in[5:0]), .sp0_pin_out(sp0_out), .sp0_pin_oe_n(sp0_oe), .sp1_pin_in(pin_in[11:6]),
        .sp1_pin_out(sp1_out), .sp1_pin_oe_n(sp1_oe), .ema_pin_in(pin_in[17:12]), .ema_pin_out(ema_out),
        .ema_pin_oe_n(ema_oe), .pp_pin_sync(pp_sync), .sp0_pin_sync(sp0_sync), .sp1_pin_sync(sp1_sync),
        .ema_pin_sync(ema_sync));
    // free-running 25 MHz clock
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic stop_test;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one request held across a single taking edge; read answer is settled on return
    task automatic io(input logic wr, input logic [15:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        io_req = '{1'b1, wr, a, d};
        @(negedge sys_clk);
        io_req.sel = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        io(1'b0, a, 16'h0000);
        chk(io_rvalid, 1'b1);
        chk(io_rdata, exp);
    endtask
    // device reset held 6 cycles, then enough edges for the strap latch to fill
    task automatic boot;
        nrst = 1'b0;
        repeat (6) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (5) @(negedge sys_clk);
    endtask
    // straps flip after the latch point to show they are ignored until reset;
    // that flip breaks the board's side on purpose, every other strap move sits in reset
    task automatic t_strap(input logic rs, input logic cs);
        reg_strap = rs;
        clk_strap = cs;
        boot;
        reg_strap = !rs;
        clk_strap = !cs;
        repeat (4) @(negedge sys_clk);
        chk(rpo, rs);
        chk({pme, cre}, {!rs, !rs});
        chk(pok, rs | ok_lvl);
        chk({eci, mce}, {cs, cs});
    endtask
    task automatic t_reg;
        rd(16'h1C00, 16'h0000);
        io(1'b1, 16'h1C00, 16'hFFFF);
        io(1'b1, 16'h1C02, 16'h0000);
        rd(16'h1C00, 16'h7F3F);
        rd(16'h1C04, 16'h0000);
        chk(pp_sync, pin_in);
    endtask
    // pin levels reach the sync outputs two edges after they move, not one
    task automatic t_sync;
        logic [20:0] old;
        old = pin_in;
        @(negedge sys_clk);
        pin_in = ~pin_in;
        @(negedge sys_clk);
        chk(pp_sync, old);
        @(negedge sys_clk);
        chk(pp_sync, pin_in);
        chk({ema_sync, sp1_sync, sp0_sync}, pin_in[17:0]);
    endtask
    function automatic logic [11:0] sp_exp(input int m, input int b);
        case (m)
            0: return sp_d[b];
            1: return (sp_d[b + 1] & 12'h03CF) | (sp_d[b + 2] & ~12'h03CF);
            2: return sp_d[b + 2];
            default: return 12'h003F;
        endcase
    endfunction
    // every serial code on both ports, new routing checked the cycle after the write;
    // one select write per boot, drive bundles frozen across it as gated peripherals would be
    task automatic t_sp;
        for (int m = 0; m < 4; m++) begin
            boot;
            io(1'b1, 16'h1C00, {4'h0, 2'(m), 2'(m), 2'h0, 6'h2A});
            chk({sp0_out, sp0_oe}, sp_exp(m, 0));
            chk({sp1_out, sp1_oe}, sp_exp(m, 3));
            chk({ema_out, ema_oe}, (sp_d[7] & 12'h0AAA) | (sp_d[6] & ~12'h0AAA));
        end
    endtask
    function automatic int pp_own(input int m, input int i);
        case (m)
            1: return i < 7 ? 1 : i < 13 ? 5 : i < 17 ? 2 : 3;
            2: return i < 8 ? 5 : 0;
            3: return i < 4 ? 1 : i < 8 ? 4 : 0;
            4: return i < 4 ? 3 : i < 8 ? 2 : 0;
            5: return i < 4 ? 1 : i < 8 ? 2 : 0;
            6: return i < 7 ? 1 : i < 11 ? 3 : i < 15 ? 4 : 5;
            default: return 0;
        endcase
    endfunction
    task automatic t_pp;
        rsb_pp_drv_s e;
        for (int m = 0; m < 8; m++) begin
            boot;
            io(1'b1, 16'h1C00, {1'b0, 3'(m), 12'h000});
            for (int i = 0; i < 21; i++) begin
                e.out[i] = pp_d[pp_own(m, i)].out[i];
                e.oe_n[i] = pp_d[pp_own(m, i)].oe_n[i];
            end
            chk(pp_out, e.out);
            chk(pp_oe, e.oe_n);
        end
    endtask
    // distinct drive patterns per bundle; a wrong owner shows only on pins where the two bundles differ
    initial begin
        pp_d[0] = {21'h00_0000, 21'h1F_FFFF};
        for (int k = 1; k < 6; k++) begin
            pp_d[k].out = 21'h13_579B * 21'(k);
            pp_d[k].oe_n = pp_d[k].out ^ 21'h0F_0F0F;
        end
        for (int k = 0; k < 8; k++) begin
            sp_d[k].out = 6'h0B * 6'(k + 1);
            sp_d[k].oe_n = sp_d[k].out ^ 6'h15;
        end
        t_strap(1'b0, 1'b0);
        ok_lvl = 1'b1;
        t_strap(1'b0, 1'b1);
        t_strap(1'b1, 1'b0);
        t_reg;
        t_sync;
        t_sp;
        t_pp;
        stop_test;
    end
    // hang guard
    initial begin
        #40000;
        n_mismatch++;
        stop_test;
    end
endmodule
